/* File: adc_setup_pkg.sv */
// Shared constants for the converter setup and calibration block.
package adc_setup_pkg;
    localparam int NCH = 4;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 8;
    localparam int REG_W = 32;

    // Rising master clock edges per modulator clock.
    localparam int MOD_CLK_DIV = 2;
    localparam logic [0:0] MOD_DIV_LAST = 1'(MOD_CLK_DIV - 1);

    // Oversampling ratio is OSR_MIN shifted left by the ratio code.
    localparam int OSR_CNT_W = 15;
    localparam logic [OSR_CNT_W-1:0] OSR_MIN = 15'h0080;

    // Global register map.
    localparam logic [ADDR_W-1:0] ADDR_GAIN = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

    // Per-channel blocks sit at reg_addr[7:5] = channel + CH_BLOCK_BASE.
    localparam int CH_SEL_LSB = 5;
    localparam int CH_BLOCK_BASE = 1;
    localparam logic [4:0] OFF_CFG = 5'h00;
    localparam logic [4:0] OFF_OCAL_HI = 5'h04;
    localparam logic [4:0] OFF_OCAL_LO = 5'h08;
    localparam logic [4:0] OFF_GCAL_HI = 5'h0c;
    localparam logic [4:0] OFF_GCAL_LO = 5'h10;
    localparam int CAL_HI_W = 16;
    localparam int CAL_LO_W = 8;

    // Gain register: three bits per channel, four bits apart.
    localparam int GAIN_CODE_W = 3;
    localparam int GAIN_STRIDE = 4;
    localparam logic [15:0] GAIN_RESET = 16'h0000;

    // Clock register fields.
    localparam int PWR_LSB = 0;
    localparam int PWR_W = 2;
    localparam int OSR_LSB = 2;
    localparam int OSR_CODE_W = 3;
    localparam int CHEN_LSB = 8;
    localparam logic [PWR_W-1:0] PWR_HIGH_RES = 2'h2;
    localparam logic [OSR_CODE_W-1:0] OSR_CODE_RESET = 3'h2;

    // Channel configuration fields.
    localparam int INSEL_LSB = 0;
    localparam int INSEL_W = 2;
    localparam int PHASE_LSB = 6;
    localparam int PHASE_W = 10;
    localparam int CFG_W = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [INSEL_W-1:0] INSEL_EXTERNAL = 2'h0;
    localparam logic [INSEL_W-1:0] INSEL_SHORTED = 2'h1;
    localparam logic [INSEL_W-1:0] INSEL_TEST_POS = 2'h2;
    localparam logic [INSEL_W-1:0] INSEL_TEST_NEG = 2'h3;
    localparam logic [DATA_W-1:0] TEST_LEVEL = 24'h100000;

    // Calibration reset values; gain factor is unsigned 1.23.
    localparam logic [DATA_W-1:0] OCAL_RESET = 24'h000000;
    localparam logic [DATA_W-1:0] GCAL_RESET = 24'h800000;
    localparam int GCAL_FRAC = 23;

    // Control register fields.
    localparam int DCB_EN_BIT = 0;
    localparam int DCB_SHIFT_LSB = 1;
    localparam int DCB_SHIFT_W = 4;
    localparam logic [DCB_SHIFT_W-1:0] DCB_SHIFT_RESET = 4'h8;

    // Status register fields.
    localparam int ST_READY_BIT = 0;
    localparam int ST_COUNT_LSB = 1;
    localparam int ST_OVF_BIT = 3;

    // Serial port mode: clock idles low, data launched on leading edge.
    localparam logic SPI_CPOL = 1'b0;
    localparam logic SPI_CPHA = 1'b1;

    typedef enum logic [1:0] {SPI_IDLE, SPI_SHIFT, SPI_DONE} spi_state_t;
endpackage : adc_setup_pkg

/* File: sample_store.sv */
// Two-entry conversion sample store with a registered read port.
`timescale 1ns/1ps
module sample_store #(
    parameter int LANES = 4,
    parameter int WIDTH = 24,
    parameter int ENTRIES = 2,
    parameter int ENTRY_AW = 1,
    parameter int LANE_AW = 2
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [ENTRY_AW-1:0] wr_entry,
    input wire logic [LANES*WIDTH-1:0] wr_data,
    input wire logic [ENTRY_AW+LANE_AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [ENTRIES*LANES];

    // A whole entry, one word per lane, is written in a single cycle.
    always_ff @(posedge sys_clk) begin
        if (clk_en && wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                mem[{wr_entry, LANE_AW'(l)}] <= wr_data[l*WIDTH +: WIDTH];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_data <= '0;
        end else if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : sample_store

/* File: adc_setup_and_calibration.sv */
// Converter setup, real-time correction and sample read-out logic.
//
// Contract
// - The modulator clock is the master clock input divided by two.
// - One sample per channel is made every oversampling ratio modulator clocks.
// - New samples are announced by a falling edge on sample_ready_n.
// - The serial port idles its clock low and the host samples on the second edge.
// - Each channel applies its own amplifier gain, with unity gain selectable.
// - Each channel configuration selects the input source and holds its phase delay.
// - The clock register holds the ratio, per-channel enables and the power mode.
// - Each channel subtracts its stored high and low offset value from the result.
// - Each offset-corrected result is multiplied by the channel gain factor.
// - Each channel samples late by its phase delay field, in modulator clocks.
// - An optional DC-blocking filter replaces register offset correction.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module adc_setup_and_calibration
    import adc_setup_pkg::*;
#(
    parameter int NUM_CH = NCH,
    parameter int SAMPLE_W = DATA_W
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    input wire logic master_clock_input,
    input wire logic [NUM_CH*SAMPLE_W-1:0] raw_data,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic sample_ready_n
);
    localparam int LANE_AW = $clog2(NUM_CH);
    localparam int BIT_CNT_W = $clog2(SAMPLE_W);
    localparam int WIDE_W = 50;

    // Clamps a wide signed value into the sample range.
    function automatic logic [SAMPLE_W-1:0] sat_w(
        input logic signed [WIDE_W-1:0] v
    );
        logic signed [WIDE_W-1:0] hi;
        logic signed [WIDE_W-1:0] lo;
        hi = {{(WIDE_W-SAMPLE_W+1){1'b0}}, {(SAMPLE_W-1){1'b1}}};
        lo = ~hi;
        if (v > hi) begin
            sat_w = hi[SAMPLE_W-1:0];
        end else if (v < lo) begin
            sat_w = lo[SAMPLE_W-1:0];
        end else begin
            sat_w = v[SAMPLE_W-1:0];
        end
    endfunction : sat_w

    logic [15:0] gain_reg;
    logic [PWR_W-1:0] power_mode;
    logic [OSR_CODE_W-1:0] osr_code;
    logic [NUM_CH-1:0] chan_en;
    logic dcb_en;
    logic [DCB_SHIFT_W-1:0] dcb_shift;
    logic [CFG_W-1:0] chan_cfg [NUM_CH];
    logic [SAMPLE_W-1:0] ocal [NUM_CH];
    logic [SAMPLE_W-1:0] gcal [NUM_CH];
    logic [NUM_CH*SAMPLE_W-1:0] proc_word;

    logic mclk_prev;
    logic mclk_rise;
    logic [0:0] mod_div_cnt;
    logic mod_tick;
    logic [OSR_CNT_W-1:0] osr_len;
    logic [OSR_CNT_W-1:0] dec_cnt;
    logic period_end;
    logic proc_go;

    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] buf_count;
    logic overflow;
    logic push;
    logic pop;
    logic ready_pending;

    spi_state_t spi_state;
    logic sclk_prev;
    logic cs_prev;
    logic lead_edge;
    logic cs_fall;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [LANE_AW-1:0] word_idx;
    logic [SAMPLE_W-1:0] shreg;
    logic [SAMPLE_W-1:0] mem_rdata;

    // Global configuration registers.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            gain_reg <= GAIN_RESET;
            power_mode <= PWR_HIGH_RES;
            osr_code <= OSR_CODE_RESET;
            chan_en <= '1;
            dcb_en <= 1'b0;
            dcb_shift <= DCB_SHIFT_RESET;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ADDR_GAIN) begin
                gain_reg <= reg_wdata[15:0];
            end else if (reg_addr == ADDR_CLOCK) begin
                power_mode <= reg_wdata[PWR_LSB +: PWR_W];
                osr_code <= reg_wdata[OSR_LSB +: OSR_CODE_W];
                chan_en <= reg_wdata[CHEN_LSB +: NUM_CH];
            end else if (reg_addr == ADDR_CONTROL) begin
                dcb_en <= reg_wdata[DCB_EN_BIT];
                dcb_shift <= reg_wdata[DCB_SHIFT_LSB +: DCB_SHIFT_W];
            end
        end
    end

    // Modulator clock: one tick per two rising master clock edges.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mclk_prev <= 1'b0;
            mod_div_cnt <= '0;
        end else if (clk_en) begin
            mclk_prev <= master_clock_input;
            if (mclk_rise) begin
                mod_div_cnt <= (mod_div_cnt == MOD_DIV_LAST) ? '0
                    : mod_div_cnt + 1'b1;
            end
        end
    end

    assign mclk_rise = master_clock_input && !mclk_prev;
    assign mod_tick = mclk_rise && (mod_div_cnt == MOD_DIV_LAST);

    // Decimation counter; a new ratio takes effect at once, and a count already past it ends the period at the next tick.
    assign osr_len = OSR_MIN << osr_code;
    assign period_end = mod_tick && (dec_cnt >= osr_len - 1'b1);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dec_cnt <= '0;
            proc_go <= 1'b0;
        end else if (clk_en) begin
            proc_go <= period_end;
            if (period_end) begin
                dec_cnt <= '0;
            end else if (mod_tick) begin
                dec_cnt <= dec_cnt + 1'b1;
            end
        end
    end

    // Per-channel registers, sampling instant and correction path.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic ch_hit;
        logic [PHASE_W-1:0] phase;
        logic [OSR_CNT_W-1:0] cap_at;
        logic [SAMPLE_W-1:0] captured;
        logic [SAMPLE_W-1:0] src;
        logic [GAIN_CODE_W-1:0] gcode;
        logic signed [WIDE_W-1:0] amp_wide;
        logic [SAMPLE_W-1:0] amp;
        logic signed [SAMPLE_W-1:0] dc_est;
        logic signed [WIDE_W-1:0] dc_diff;
        logic [SAMPLE_W-1:0] off_val;
        logic [SAMPLE_W-1:0] corr;
        logic signed [WIDE_W-1:0] prod;
        logic [SAMPLE_W-1:0] scaled;

        assign ch_hit = clk_en && reg_wr && (reg_addr[ADDR_W-1:CH_SEL_LSB]
            == 3'(c + CH_BLOCK_BASE));

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                chan_cfg[c] <= CFG_RESET;
                ocal[c] <= OCAL_RESET;
                gcal[c] <= GCAL_RESET;
            end else if (ch_hit) begin
                if (reg_addr[CH_SEL_LSB-1:0] == OFF_CFG) begin
                    chan_cfg[c] <= reg_wdata[CFG_W-1:0];
                end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_OCAL_HI) begin
                    ocal[c][CAL_LO_W +: CAL_HI_W] <= reg_wdata[CAL_HI_W-1:0];
                end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_OCAL_LO) begin
                    ocal[c][CAL_LO_W-1:0] <= reg_wdata[CAL_LO_W-1:0];
                end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_GCAL_HI) begin
                    gcal[c][CAL_LO_W +: CAL_HI_W] <= reg_wdata[CAL_HI_W-1:0];
                end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_GCAL_LO) begin
                    gcal[c][CAL_LO_W-1:0] <= reg_wdata[CAL_LO_W-1:0];
                end
            end
        end

        // A delay longer than the period samples at its last tick.
        assign phase = chan_cfg[c][PHASE_LSB +: PHASE_W];
        assign cap_at = (OSR_CNT_W'(phase) < osr_len)
            ? OSR_CNT_W'(phase) : osr_len - 1'b1;

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                captured <= '0;
            end else if (clk_en && mod_tick && dec_cnt == cap_at) begin
                captured <= raw_data[c*SAMPLE_W +: SAMPLE_W];
            end
        end

        always_comb begin
            case (chan_cfg[c][INSEL_LSB +: INSEL_W])
                INSEL_EXTERNAL: src = captured;
                INSEL_SHORTED: src = '0;
                INSEL_TEST_POS: src = TEST_LEVEL;
                default: src = -TEST_LEVEL;
            endcase
        end

        // Gain is a power of two; code zero is unity.
        assign gcode = gain_reg[c*GAIN_STRIDE +: GAIN_CODE_W];
        assign amp_wide = WIDE_W'($signed(src)) <<< gcode;
        assign amp = sat_w(amp_wide);

        // The filter tracks the input mean and subtracts it.
        assign dc_diff = WIDE_W'($signed(amp)) - WIDE_W'(dc_est);

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                dc_est <= '0;
            end else if (clk_en && proc_go && dcb_en) begin
                dc_est <= dc_est + SAMPLE_W'(dc_diff >>> dcb_shift);
            end
        end

        assign off_val = dcb_en ? dc_est : ocal[c];
        assign corr = sat_w(WIDE_W'($signed(amp))
            - WIDE_W'($signed(off_val)));
        assign prod = WIDE_W'($signed(corr))
            * WIDE_W'($signed({1'b0, gcal[c]}));
        assign scaled = sat_w(prod >>> GCAL_FRAC);

        // Disabled channels still fill their frame slot, with zero.
        assign proc_word[c*SAMPLE_W +: SAMPLE_W] = chan_en[c]
            ? scaled : '0;
    end

    // Two-deep buffer bookkeeping; an overflow drops the oldest entry.
    assign push = proc_go;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_count <= 2'h0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop && buf_count != 2'h0) begin
                rd_ptr <= ~rd_ptr;
            end else if (push && buf_count == 2'h2) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !(pop && buf_count != 2'h0) && buf_count != 2'h2) begin
                buf_count <= buf_count + 2'h1;
            end else if (!push && pop && buf_count != 2'h0) begin
                buf_count <= buf_count - 2'h1;
            end
        end
    end

    // Sticky overflow; a new overflow wins over a clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            overflow <= 1'b0;
        end else if (clk_en) begin
            if (push && buf_count == 2'h2 && !pop) begin
                overflow <= 1'b1;
            end else if (reg_wr && reg_addr == ADDR_STATUS
                && reg_wdata[ST_OVF_BIT]) begin
                overflow <= 1'b0;
            end
        end
    end

    // Ready goes high when a frame starts and falls once a corrected
    // entry is stored; if it is already low it first rises for a cycle
    // so that every new sample produces its own falling edge.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sample_ready_n <= 1'b1;
            ready_pending <= 1'b0;
        end else if (clk_en) begin
            if (push && !sample_ready_n) begin
                sample_ready_n <= 1'b1;
                ready_pending <= 1'b1;
            end else if (push || ready_pending) begin
                sample_ready_n <= 1'b0;
                ready_pending <= 1'b0;
            end else if (cs_fall) begin
                sample_ready_n <= 1'b1;
            end
        end
    end

    sample_store #(
        .LANES(NUM_CH),
        .WIDTH(SAMPLE_W),
        .ENTRIES(2),
        .ENTRY_AW(1),
        .LANE_AW(LANE_AW)
    ) u_store (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .wr_en(push),
        .wr_entry(wr_ptr),
        .wr_data(proc_word),
        .rd_addr({rd_ptr, word_idx}),
        .rd_data(mem_rdata)
    );

    // Serial read-out. With the clock idling low and data taken on the
    // second edge, a bit is launched on each leading edge.
    assign lead_edge = (spi_sclk != SPI_CPOL) && (sclk_prev == SPI_CPOL)
        && SPI_CPHA;
    assign cs_fall = !spi_cs_n && cs_prev;
    assign pop = (spi_state == SPI_DONE) && spi_cs_n;
    assign spi_miso_oe = !spi_cs_n;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclk_prev <= SPI_CPOL;
            cs_prev <= 1'b1;
        end else if (clk_en) begin
            sclk_prev <= spi_sclk;
            cs_prev <= spi_cs_n;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            spi_state <= SPI_IDLE;
            bit_cnt <= '0;
            word_idx <= '0;
            shreg <= '0;
            spi_miso <= 1'b0;
        end else if (clk_en) begin
            case (spi_state)
                SPI_IDLE: begin
                    bit_cnt <= '0;
                    word_idx <= '0;
                    if (!spi_cs_n) begin
                        spi_state <= SPI_SHIFT;
                    end
                end
                SPI_SHIFT: begin
                    if (spi_cs_n) begin
                        spi_state <= SPI_IDLE;
                    end else if (lead_edge) begin
                        if (bit_cnt == '0) begin
                            spi_miso <= mem_rdata[SAMPLE_W-1];
                            shreg <= mem_rdata << 1;
                        end else begin
                            spi_miso <= shreg[SAMPLE_W-1];
                            shreg <= shreg << 1;
                        end
                        if (bit_cnt == BIT_CNT_W'(SAMPLE_W - 1)) begin
                            bit_cnt <= '0;
                            word_idx <= word_idx + 1'b1;
                            if (word_idx == LANE_AW'(NUM_CH - 1)) begin
                                spi_state <= SPI_DONE;
                            end
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
                default: begin
                    if (spi_cs_n) begin
                        spi_state <= SPI_IDLE;
                    end
                end
            endcase
        end
    end

    // Register read-back, one cycle after the strobe.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= '0;
            if (reg_addr == ADDR_GAIN) begin
                reg_rdata[15:0] <= gain_reg;
            end else if (reg_addr == ADDR_CLOCK) begin
                reg_rdata[PWR_LSB +: PWR_W] <= power_mode;
                reg_rdata[OSR_LSB +: OSR_CODE_W] <= osr_code;
                reg_rdata[CHEN_LSB +: NUM_CH] <= chan_en;
            end else if (reg_addr == ADDR_CONTROL) begin
                reg_rdata[DCB_EN_BIT] <= dcb_en;
                reg_rdata[DCB_SHIFT_LSB +: DCB_SHIFT_W] <= dcb_shift;
            end else if (reg_addr == ADDR_STATUS) begin
                reg_rdata[ST_READY_BIT] <= !sample_ready_n;
                reg_rdata[ST_COUNT_LSB +: 2] <= buf_count;
                reg_rdata[ST_OVF_BIT] <= overflow;
            end else begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (reg_addr[ADDR_W-1:CH_SEL_LSB] == 3'(c + CH_BLOCK_BASE))
                    begin
                        if (reg_addr[CH_SEL_LSB-1:0] == OFF_CFG) begin
                            reg_rdata[CFG_W-1:0] <= chan_cfg[c];
                        end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_OCAL_HI)
                        begin
                            reg_rdata[CAL_HI_W-1:0] <=
                                ocal[c][CAL_LO_W +: CAL_HI_W];
                        end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_OCAL_LO)
                        begin
                            reg_rdata[CAL_LO_W-1:0] <= ocal[c][CAL_LO_W-1:0];
                        end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_GCAL_HI)
                        begin
                            reg_rdata[CAL_HI_W-1:0] <=
                                gcal[c][CAL_LO_W +: CAL_HI_W];
                        end else if (reg_addr[CH_SEL_LSB-1:0] == OFF_GCAL_LO)
                        begin
                            reg_rdata[CAL_LO_W-1:0] <= gcal[c][CAL_LO_W-1:0];
                        end
                    end
                end
            end
        end
    end
endmodule : adc_setup_and_calibration

/* File: adc_setup_checks_properties.sv */
// Port-level timing checks for the converter setup block.
`timescale 1ns/1ps
module adc_setup_checks
    import adc_setup_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [REG_W-1:0] reg_rdata,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe,
    input wire logic sample_ready_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    AST_RESET: assert property (disable iff (1'b0)
        !resetn && clk_en |=> sample_ready_n && reg_rdata == '0)
        else $error("reset state wrong");
    AST_OE: assert property (spi_miso_oe == !spi_cs_n)
        else $error("miso enable wrong");
    AST_MISO_STILL: assert property (
        (!spi_cs_n && !spi_sclk)[*3] |=> $stable(spi_miso))
        else $error("miso moved without clock");
    AST_READY_CS: assert property (
        $fell(spi_cs_n) |-> ##[1:2] sample_ready_n)
        else $error("ready not cleared by select");
    AST_GAP: assert property (
        $fell(sample_ready_n) |=> (!$fell(sample_ready_n))[*8])
        else $error("ready edges too close");
    AST_UNMAPPED: assert property (
        reg_rd && clk_en && reg_addr == 8'hf0 |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (
        !(reg_rd && clk_en) |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_FREEZE: assert property (
        !clk_en |=> $stable(sample_ready_n) && $stable(spi_miso))
        else $error("state moved while disabled");
endmodule : adc_setup_checks

/* File: host_mcu_model.sv */
// Host model: master clock source and serial frame reader.
`timescale 1ns/1ps
module host_mcu_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sample_ready_n,
    input wire logic spi_miso,
    output logic master_clock_input,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic [95:0] frame,
    output logic frame_valid
);
    logic ph = 1'b0;
    initial master_clock_input = 1'b0;
    // Four system cycles a period keeps the clock under half the rate.
    always @(posedge sys_clk) begin
        ph <= ~ph;
        if (ph) master_clock_input <= ~master_clock_input;
    end
    // Half period of 3 cycles ends a frame well within one sample period.
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        frame_valid = 1'b0;
        frame = '0;
        forever begin
            @(posedge sys_clk);
            if (resetn === 1'b1 && sample_ready_n === 1'b0) begin
                spi_cs_n <= 1'b0;
                for (int b = 95; b >= 0; b--) begin
                    repeat (3) @(posedge sys_clk);
                    spi_sclk <= 1'b1;
                    repeat (3) @(posedge sys_clk);
                    spi_sclk <= 1'b0;
                    frame[b] <= spi_miso;
                end
                spi_cs_n <= 1'b1;
                frame_valid <= 1'b1;
                @(posedge sys_clk);
                frame_valid <= 1'b0;
                @(posedge sys_clk);
            end
        end
    end
endmodule : host_mcu_model

/* File: adc_setup_and_calibration_tb.sv */
// Self-checking bench for the converter setup block.
`timescale 1ns/1ps
module adc_setup_and_calibration_tb
    import adc_setup_pkg::*;
;
    logic sys_clk = 0, resetn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [95:0] raw_data = '0, frame;
    logic mclk, sclk, cs_n, miso, oe, rdy_n, fv, rdy_d = 1, meas = 0;
    int num_errors = 0, compares = 0, gap = 0;
    logic [95:0] q[$];
    always #5 sys_clk = ~sys_clk;
    adc_setup_and_calibration u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_clock_input(mclk), .raw_data(raw_data), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_miso(miso), .spi_miso_oe(oe),
        .sample_ready_n(rdy_n));
    host_mcu_model u_host (.sys_clk(sys_clk), .resetn(resetn),
        .sample_ready_n(rdy_n), .spi_miso(miso), .master_clock_input(mclk),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .frame(frame), .frame_valid(fv));
    task automatic check(string what, logic [95:0] e, logic [95:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        check("register", 96'(e), 96'(reg_rdata));
    endtask : rd_chk
    function automatic logic [23:0] cor(logic signed [23:0] s, int g,
        logic signed [23:0] o, logic [23:0] k);
        longint v;
        v = ((longint'(s) <<< g) - longint'(o)) * longint'(k);
        return 24'(v >>> 23);
    endfunction : cor
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        rdy_d <= rdy_n;
        gap <= gap + 1;
        if (rdy_d === 1'b1 && rdy_n === 1'b0) begin
            if (meas) check("period", 96'(1024), 96'(gap));
            gap <= 1;
        end
        if (fv === 1'b1 && q.size() > 0)
            check("frame", q.pop_front(), frame);
    end
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end
    initial begin
        logic [23:0] s[4], o[4], k[4], w[4];
        int g[4];
        logic [31:0] gw;
        void'($urandom(17071));
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_chk(ADDR_CLOCK, 32'h00000f0a);
        rd_chk(ADDR_GAIN, 32'h0);
        rd_chk(8'hf0, 32'h0);
        rd_chk(ADDR_CONTROL, 32'h10);
        clk_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        clk_en <= 1'b1;
        // Shortest ratio, channel 3 off, high-resolution power mode.
        wr(ADDR_CLOCK, 32'h00000702);
        rd_chk(ADDR_CLOCK, 32'h00000702);
        repeat (2) begin
            gw = '0;
            for (int c = 0; c < 4; c++) begin
                g[c] = $urandom_range(0, 2);
                s[c] = 24'($urandom_range(0, 32767) * 2) - 24'h8000;
                o[c] = 24'($urandom_range(0, 2047) * 2) - 24'h800;
                k[c] = 24'h400000 * 24'($urandom_range(1, 3));
                gw[4*c +: 3] = 3'(g[c]);
                wr(8'((c + 1) * 32 + OFF_OCAL_HI), 32'(o[c][23:8]));
                wr(8'((c + 1) * 32 + OFF_OCAL_LO), 32'(o[c][7:0]));
                wr(8'((c + 1) * 32 + OFF_GCAL_HI), 32'(k[c][23:8]));
                wr(8'((c + 1) * 32 + OFF_GCAL_LO), 32'(k[c][7:0]));
                w[c] = c == 3 ? 24'h0 :
                    cor(c == 2 ? TEST_LEVEL : s[c], g[c], o[c], k[c]);
            end
            wr(8'h40, 32'h00000140);
            wr(8'h60, 32'(INSEL_TEST_POS));
            wr(ADDR_GAIN, gw);
            raw_data <= {s[3], s[2], s[1], s[0]};
            // Older samples may still sit in the store, so skip them.
            repeat (4) @(posedge fv);
            q.push_back({w[0], w[1], w[2], w[3]});
            meas <= 1'b1;
            repeat (2) @(posedge sys_clk);
        end
        conclude();
    end
endmodule : adc_setup_and_calibration_tb
bind adc_setup_and_calibration adc_setup_checks u_chk (.sys_clk(sys_clk),
    .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .sample_ready_n(sample_ready_n));
